// ---- logic/sllf_pkg.sv ----
// Package of constants for the serial loader link front end.
package sllf_pkg;
    localparam int          CLK_HZ         = 125000000;
    localparam int          DIV_W          = 16;
    localparam logic [7:0]  SYNC_BYTE      = 8'h55;
    localparam logic [7:0]  ACK_BYTE       = 8'hcc;
    localparam int          DATA_BITS      = 8;
    localparam int          STOP_BITS      = 1;
    localparam int          OVERSAMPLE     = 16;
    localparam int          AUTOBAUD_RATIO = 32;
    localparam int          SYNC_EDGES     = 9;
    localparam int          SPI_CPOL       = 1;
    localparam int          SPI_CPHA       = 1;
    localparam logic [DIV_W-1:0] MIN_BIT_DIV = 16'(OVERSAMPLE);
    localparam logic [DIV_W-1:0] DIV_MAX     = 16'hffff;
    typedef enum logic [1:0] {SLLF_PORT_NONE, SLLF_PORT_UART, SLLF_PORT_SSI} sllf_port_t;
    typedef enum logic [2:0] {SLLF_AB_IDLE, SLLF_AB_MEAS, SLLF_AB_DONE} sllf_ab_t;
    typedef enum logic [1:0] {SLLF_RX_IDLE, SLLF_RX_START, SLLF_RX_DATA, SLLF_RX_STOP} sllf_rx_t;
    typedef enum logic [1:0] {SLLF_TX_IDLE, SLLF_TX_START, SLLF_TX_DATA, SLLF_TX_STOP} sllf_tx_t;
endpackage

// ---- logic/sllf_frontend.sv ----
// Link front end of a serial loader: port lock, auto-baud UART and mode-3 SPI slave.
`timescale 1ns/1ps
module sllf_frontend
    import sllf_pkg::*;
(
    input  wire logic       core_clk_i,   // Crystal clock, 125 MHz
    input  wire logic       rstn_i,       // Asynchronous reset, active low
    input  wire logic       uart_rx_i,    // UART receive pin
    output logic            uart_tx_o,    // UART transmit pin
    input  wire logic       spi_clk_i,    // SPI clock from host
    input  wire logic       spi_csn_i,    // SPI chip select, active low
    input  wire logic       spi_mosi_i,   // SPI data from host
    output logic            spi_miso_o,   // SPI data to host
    output logic            spi_miso_oe_o,// SPI data output enable
    input  wire logic [7:0] tx_data_i,    // Byte to send
    input  wire logic       tx_valid_i,   // Byte to send is valid
    output logic            tx_ready_o,   // Byte accepted
    output logic [7:0]      rx_data_o,    // Received byte
    output logic            rx_valid_o,   // Received byte strobe
    output logic            synced_o,     // UART rate locked
    output logic [1:0]      port_o        // Locked port
);
    // Two-flop synchronisers; the first stage is read only by the second.
    logic [1:0] rx_s_r, sck_s_r, csn_s_r, mosi_s_r;
    logic       sck_d_r;
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rx_s_r   <= 2'h3;
            sck_s_r  <= 2'h3;
            csn_s_r  <= 2'h3;
            mosi_s_r <= 2'h0;
            sck_d_r  <= 1'b1;
        end
        else
        begin
            rx_s_r   <= {rx_s_r[0], uart_rx_i};
            sck_s_r  <= {sck_s_r[0], spi_clk_i};
            csn_s_r  <= {csn_s_r[0], spi_csn_i};
            mosi_s_r <= {mosi_s_r[0], spi_mosi_i};
            sck_d_r  <= sck_s_r[1];
        end
    end
    wire logic rx     = rx_s_r[1];
    wire logic csn    = csn_s_r[1];
    wire logic sck_rise = ~csn & sck_s_r[1] & ~sck_d_r;
    wire logic sck_fall = ~csn & ~sck_s_r[1] & sck_d_r;

    // Auto-baud and port lock state.
    sllf_port_t       port_r, port_nxt;
    sllf_ab_t         ab_r, ab_nxt;
    logic             rx_d_r, rx_d_nxt;
    logic [3:0]       edg_r, edg_nxt;
    logic [DIV_W+3:0] cnt_r, cnt_nxt;
    logic [DIV_W-1:0] div_r, div_nxt;
    logic             ack_r, ack_nxt;

    // UART receiver state.
    sllf_rx_t         rxs_r, rxs_nxt;
    logic [DIV_W-1:0] rtk_r, rtk_nxt;
    logic [2:0]       rbit_r, rbit_nxt;
    logic [7:0]       rsh_r, rsh_nxt;
    logic [1:0]       rarm_r, rarm_nxt;
    localparam logic [1:0] RX_ARM_BITS = 2'h2;

    // UART transmitter state.
    sllf_tx_t         txs_r, txs_nxt;
    logic [DIV_W-1:0] ttk_r, ttk_nxt;
    logic [2:0]       tbit_r, tbit_nxt;
    logic [7:0]       tsh_r, tsh_nxt;
    logic             txo_r, txo_nxt;

    // SPI slave state.
    logic [2:0]       sbit_r, sbit_nxt;
    logic [7:0]       srx_r, srx_nxt;
    logic [7:0]       stx_r, stx_nxt;
    logic             smiso_r, smiso_nxt;
    logic             sload_r, sload_nxt;

    logic [7:0]       rxd_r, rxd_nxt;
    logic             rxv_r, rxv_nxt;

    wire logic uart_ok = (port_r != SLLF_PORT_SSI);
    wire logic ssi_ok  = (port_r != SLLF_PORT_UART);

    always_comb
    begin
        port_nxt = port_r;
        ab_nxt   = ab_r;
        rx_d_nxt = rx;
        edg_nxt  = edg_r;
        cnt_nxt  = cnt_r;
        div_nxt  = div_r;
        ack_nxt  = 1'b0;
        rxs_nxt  = rxs_r;
        rtk_nxt  = rtk_r;
        rbit_nxt = rbit_r;
        rsh_nxt  = rsh_r;
        rarm_nxt = rarm_r;
        txs_nxt  = txs_r;
        ttk_nxt  = ttk_r;
        tbit_nxt = tbit_r;
        tsh_nxt  = tsh_r;
        txo_nxt  = txo_r;
        sbit_nxt = sbit_r;
        srx_nxt  = srx_r;
        stx_nxt  = stx_r;
        smiso_nxt = smiso_r;
        sload_nxt = sload_r;
        rxd_nxt  = rxd_r;
        rxv_nxt  = 1'b0;
        tx_ready_o = 1'b0;

        // Sync pattern: the span from the first falling edge to the ninth
        // falling edge covers sixteen bit times, so the bit divisor is cnt/16.
        case (ab_r)
            SLLF_AB_IDLE:
            begin
                if (uart_ok && rx_d_r && !rx)
                begin
                    ab_nxt   = SLLF_AB_MEAS;
                    edg_nxt  = 4'h1;
                    cnt_nxt  = '0;
                    port_nxt = SLLF_PORT_UART;
                end
            end
            SLLF_AB_MEAS:
            begin
                cnt_nxt = cnt_r + 1'b1;
                if (rx_d_r && !rx)
                begin
                    edg_nxt = edg_r + 1'b1;
                    if (edg_r == 4'(SYNC_EDGES - 1))
                    begin
                        ab_nxt  = SLLF_AB_DONE;
                        ack_nxt = 1'b1;
                        if (cnt_nxt[DIV_W+3:4] < MIN_BIT_DIV)
                            div_nxt = MIN_BIT_DIV;
                        else
                            div_nxt = cnt_nxt[DIV_W+3:4];
                    end
                end
                if (cnt_r == '1)
                    ab_nxt = SLLF_AB_IDLE;
            end
            SLLF_AB_DONE: ab_nxt = SLLF_AB_DONE;
            default: ab_nxt = SLLF_AB_IDLE;
        endcase

        // 8N1 receiver, only active once the rate is locked.
        case (rxs_r)
            SLLF_RX_IDLE:
                if (ab_r != SLLF_AB_DONE)
                    rarm_nxt = 2'h0;
                else if (rarm_r != RX_ARM_BITS)
                begin
                    // The sync tail never idles for two bit times, so wait for that first.
                    rtk_nxt = (!rx || rtk_r == '0) ? div_r - 1'b1 : rtk_r - 1'b1;
                    if (!rx)
                        rarm_nxt = 2'h0;
                    else if (rtk_r == '0)
                        rarm_nxt = rarm_r + 1'b1;
                end
                else if (!rx)
                begin
                    rxs_nxt = SLLF_RX_START;
                    rtk_nxt = {1'b0, div_r[DIV_W-1:1]};
                end
            SLLF_RX_START:
                if (rtk_r == '0)
                begin
                    rxs_nxt  = rx ? SLLF_RX_IDLE : SLLF_RX_DATA;
                    rtk_nxt  = div_r - 1'b1;
                    rbit_nxt = '0;
                end
                else
                    rtk_nxt = rtk_r - 1'b1;
            SLLF_RX_DATA:
                if (rtk_r == '0)
                begin
                    rsh_nxt  = {rx, rsh_r[7:1]};
                    rtk_nxt  = div_r - 1'b1;
                    rbit_nxt = rbit_r + 1'b1;
                    if (rbit_r == 3'(DATA_BITS - 1))
                        rxs_nxt = SLLF_RX_STOP;
                end
                else
                    rtk_nxt = rtk_r - 1'b1;
            SLLF_RX_STOP:
                if (rtk_r == '0)
                begin
                    rxs_nxt = SLLF_RX_IDLE;
                    if (rx)
                    begin
                        rxd_nxt = rsh_r;
                        rxv_nxt = 1'b1;
                    end
                end
                else
                    rtk_nxt = rtk_r - 1'b1;
            default: rxs_nxt = SLLF_RX_IDLE;
        endcase

        // 8N1 transmitter at the detected rate.
        case (txs_r)
            SLLF_TX_IDLE:
            begin
                txo_nxt = 1'b1;
                if (ack_r || (ab_r == SLLF_AB_DONE && tx_valid_i))
                begin
                    tx_ready_o = ~ack_r;
                    tsh_nxt = ack_r ? ACK_BYTE : tx_data_i;
                    txs_nxt = SLLF_TX_START;
                    ttk_nxt = div_r - 1'b1;
                    txo_nxt = 1'b0;
                end
            end
            SLLF_TX_START, SLLF_TX_DATA:
                if (ttk_r == '0)
                begin
                    ttk_nxt = div_r - 1'b1;
                    if (txs_r == SLLF_TX_START)
                        tbit_nxt = '0;
                    else
                    begin
                        tbit_nxt = tbit_r + 1'b1;
                        tsh_nxt  = {1'b1, tsh_r[7:1]};
                    end
                    txs_nxt = SLLF_TX_DATA;
                    txo_nxt = (txs_r == SLLF_TX_START) ? tsh_r[0] : tsh_r[1];
                    if (txs_r == SLLF_TX_DATA && tbit_r == 3'(DATA_BITS - 1))
                    begin
                        txs_nxt = SLLF_TX_STOP;
                        txo_nxt = 1'b1;
                    end
                end
                else
                    ttk_nxt = ttk_r - 1'b1;
            SLLF_TX_STOP:
                if (ttk_r == '0)
                    txs_nxt = SLLF_TX_IDLE;
                else
                    ttk_nxt = ttk_r - 1'b1;
            default: txs_nxt = SLLF_TX_IDLE;
        endcase

        // Mode 3 slave: shift out on falling edge, capture on rising edge.
        if (csn)
        begin
            sbit_nxt  = '0;
            sload_nxt = 1'b1;
        end
        else if (ssi_ok && port_nxt != SLLF_PORT_UART)
        begin
            port_nxt = SLLF_PORT_SSI;
            if (sload_r)
            begin
                sload_nxt  = 1'b0;
                tx_ready_o = tx_valid_i;
                stx_nxt    = tx_valid_i ? tx_data_i : 8'h00;
                smiso_nxt  = tx_valid_i ? tx_data_i[7] : 1'b0;
            end
            if (sck_fall && sbit_r != 3'h0)
            begin
                smiso_nxt = stx_r[7];
            end
            if (sck_rise)
            begin
                srx_nxt  = {srx_r[6:0], mosi_s_r[1]};
                stx_nxt  = {stx_r[6:0], 1'b0};
                sbit_nxt = sbit_r + 1'b1;
                if (sbit_r == 3'h7)
                begin
                    rxd_nxt   = {srx_r[6:0], mosi_s_r[1]};
                    rxv_nxt   = 1'b1;
                    sload_nxt = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            port_r  <= SLLF_PORT_NONE;
            ab_r    <= SLLF_AB_IDLE;
            rx_d_r  <= 1'b1;
            edg_r   <= '0;
            cnt_r   <= '0;
            div_r   <= DIV_MAX;
            ack_r   <= 1'b0;
            rxs_r   <= SLLF_RX_IDLE;
            rtk_r   <= '0;
            rbit_r  <= '0;
            rsh_r   <= '0;
            rarm_r  <= 2'h0;
            txs_r   <= SLLF_TX_IDLE;
            ttk_r   <= '0;
            tbit_r  <= '0;
            tsh_r   <= '0;
            txo_r   <= 1'b1;
            sbit_r  <= '0;
            srx_r   <= '0;
            stx_r   <= '0;
            smiso_r <= 1'b0;
            sload_r <= 1'b1;
            rxd_r   <= '0;
            rxv_r   <= 1'b0;
        end
        else
        begin
            port_r  <= port_nxt;
            ab_r    <= ab_nxt;
            rx_d_r  <= rx_d_nxt;
            edg_r   <= edg_nxt;
            cnt_r   <= cnt_nxt;
            div_r   <= div_nxt;
            ack_r   <= ack_nxt;
            rxs_r   <= rxs_nxt;
            rtk_r   <= rtk_nxt;
            rbit_r  <= rbit_nxt;
            rsh_r   <= rsh_nxt;
            rarm_r  <= rarm_nxt;
            txs_r   <= txs_nxt;
            ttk_r   <= ttk_nxt;
            tbit_r  <= tbit_nxt;
            tsh_r   <= tsh_nxt;
            txo_r   <= txo_nxt;
            sbit_r  <= sbit_nxt;
            srx_r   <= srx_nxt;
            stx_r   <= stx_nxt;
            smiso_r <= smiso_nxt;
            sload_r <= sload_nxt;
            rxd_r   <= rxd_nxt;
            rxv_r   <= rxv_nxt;
        end
    end

    assign uart_tx_o     = txo_r;
    assign spi_miso_o    = smiso_r;
    assign spi_miso_oe_o = ~csn & (port_r == SLLF_PORT_SSI);
    assign rx_data_o     = rxd_r;
    assign rx_valid_o    = rxv_r;
    assign synced_o      = (ab_r == SLLF_AB_DONE);
    assign port_o        = port_r;
endmodule

// ---- bench/sllf_checker.sv ----
// Port-level assertions for the serial loader link front end.
`timescale 1ns/1ps
module sllf_checker (
    input wire logic       core_clk_i,    // Core clock
    input wire logic       rstn_i,        // Reset, active low
    input wire logic       uart_tx_o,     // UART line out
    input wire logic       spi_miso_oe_o, // MISO enable
    input wire logic       tx_valid_i,    // Send request
    input wire logic       tx_ready_o,    // Send accepted
    input wire logic       rx_valid_o,    // Receive strobe
    input wire logic       synced_o,      // Rate locked
    input wire logic [1:0] port_o         // Locked port
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);
    property p_lock_hold; port_o != 2'h0 |=> port_o == $past(port_o); endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("port lock changed");
    property p_ssi_quiet; port_o == 2'h2 |-> uart_tx_o && !synced_o; endproperty
    a_ssi_quiet: assert property (p_ssi_quiet) else $error("uart active on ssi lock");
    property p_oe_port; spi_miso_oe_o |-> port_o == 2'h2; endproperty
    a_oe_port: assert property (p_oe_port) else $error("miso driven without ssi lock");
    property p_presync_tx; !synced_o |-> uart_tx_o; endproperty
    a_presync_tx: assert property (p_presync_tx) else $error("uart sent before sync");
    property p_presync_rx; rx_valid_o |-> synced_o || port_o == 2'h2; endproperty
    a_presync_rx: assert property (p_presync_rx) else $error("byte passed before sync");
    property p_ack_start; $rose(synced_o) |-> ##[1:3] !uart_tx_o; endproperty
    a_ack_start: assert property (p_ack_start) else $error("no ack after sync");
    property p_sync_hold; synced_o |=> synced_o; endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("sync lost");
    property p_min_bit; $fell(uart_tx_o) |-> !uart_tx_o[*8] ##1 !uart_tx_o[*8]; endproperty
    a_min_bit: assert property (p_min_bit) else $error("start bit under 16 clocks");
    property p_ready; tx_ready_o |-> tx_valid_i; endproperty
    a_ready: assert property (p_ready) else $error("ready without request");
endmodule

bind sllf_frontend sllf_checker u_sllf_checker (
    .core_clk_i   (core_clk_i),
    .rstn_i       (rstn_i),
    .uart_tx_o    (uart_tx_o),
    .spi_miso_oe_o(spi_miso_oe_o),
    .tx_valid_i   (tx_valid_i),
    .tx_ready_o   (tx_ready_o),
    .rx_valid_o   (rx_valid_o),
    .synced_o     (synced_o),
    .port_o       (port_o)
);

// ---- bench/sllf_host.sv ----
// Host model: UART 8N1 master and mode-3 SPI master.
`timescale 1ns/1ps
module sllf_host (
    output logic      uart_rx_o,     // Host to device line
    input  wire logic uart_tx_i,     // Device to host line
    output logic      spi_clk_o,     // SPI clock, idles high
    output logic      spi_csn_o,     // SPI select
    output logic      spi_mosi_o,    // SPI data out
    input  wire logic spi_miso_i,    // SPI data in
    input  wire logic spi_miso_oe_i  // SPI data enable
);
    initial
    begin
        uart_rx_o = 1'b1;
        spi_clk_o = 1'b1;
        spi_csn_o = 1'b1;
        spi_mosi_o = 1'b0;
    end
    task automatic uart_send(input logic [7:0] b, input int bit_ns);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            uart_rx_o = f[i];
            #(bit_ns);
        end
    endtask
    task automatic uart_recv(output logic [7:0] b, output bit ok, input int bit_ns);
        int t;
        b = 8'h00;
        ok = 1'b0;
        for (t = 0; t < 5 * bit_ns && uart_tx_i !== 1'b0; t++)
            #8;
        if (uart_tx_i === 1'b0)
        begin
            #(bit_ns / 2);
            for (int i = 0; i < 8; i++)
            begin
                #(bit_ns);
                b[i] = uart_tx_i;
            end
            #(bit_ns);
            ok = (uart_tx_i === 1'b1);
        end
    endtask
    // A 125 ns clock stays under the one-twelfth limit; it stands still between frames.
    task automatic spi_xfer(input logic [7:0] tx, output logic [7:0] rx);
        spi_csn_o = 1'b0;
        #250;
        for (int i = 0; i < 8; i++)
        begin
            spi_clk_o = 1'b0;
            spi_mosi_o = tx[7-i];
            #62;
            spi_clk_o = 1'b1;
            rx[7-i] = spi_miso_oe_i ? spi_miso_i : ~spi_miso_i;
            #63;
        end
        #250;
        spi_csn_o = 1'b1;
        spi_mosi_o = ~spi_mosi_o;
    endtask
endmodule

// ---- bench/test_sllf_frontend.sv ----
// Self-checking bench for the serial loader link front end.
`timescale 1ns/1ps
module test_sllf_frontend;
    import sllf_pkg::*;
    logic        core_clk_i, rstn_i, uart_rx_i, uart_tx_o, spi_clk_i, spi_csn_i;
    logic        spi_mosi_i, spi_miso_o, spi_miso_oe_o, tx_valid_i, tx_ready_o;
    logic        rx_valid_o, synced_o;
    logic [7:0]  tx_data_i, rx_data_o, rx_last;
    logic [1:0]  port_o;
    logic [31:0] seed;
    int          n_fail, checks, n_rx;

    sllf_frontend i_sllf_frontend (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .uart_rx_i(uart_rx_i), .uart_tx_o(uart_tx_o), .spi_clk_i(spi_clk_i),
        .spi_csn_i(spi_csn_i), .spi_mosi_i(spi_mosi_i), .spi_miso_o(spi_miso_o),
        .spi_miso_oe_o(spi_miso_oe_o), .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i),
        .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
        .synced_o(synced_o), .port_o(port_o));
    sllf_host i_sllf_host (.uart_rx_o(uart_rx_i), .uart_tx_i(uart_tx_o),
        .spi_clk_o(spi_clk_i), .spi_csn_o(spi_csn_i), .spi_mosi_o(spi_mosi_i),
        .spi_miso_i(spi_miso_o), .spi_miso_oe_i(spi_miso_oe_o));

    initial
    begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i)
        if (rx_valid_o === 1'b1)
        begin
            rx_last = rx_data_o;
            n_rx++;
        end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic end_sim();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic do_reset();
        rstn_i = 1'b0;
        repeat (5) @(posedge core_clk_i);
        #1 rstn_i = 1'b1;
        repeat (4) @(posedge core_clk_i);
        #1;
    endtask
    task automatic offer(input logic [7:0] v);
        int k;
        @(posedge core_clk_i);
        #1;
        tx_data_i = v;
        tx_valid_i = 1'b1;
        for (k = 0; k < 20000; k++)
        begin
            @(negedge core_clk_i);
            if (tx_ready_o === 1'b1)
                break;
        end
        if (k == 20000)
        begin
            n_fail++;
            end_sim();
        end
        @(posedge core_clk_i);
        #1;
        tx_valid_i = 1'b0;
    endtask
    task automatic wait_rx(input int n0);
        int k;
        for (k = 0; k < 200 && n_rx == n0; k++)
            @(posedge core_clk_i);
        if (n_rx == n0)
        begin
            n_fail++;
            end_sim();
        end
    endtask

    initial
    begin
        logic [7:0] b, m, r;
        bit         ok;
        int         bit_ns, n0;
        {tx_data_i, tx_valid_i, n_fail, checks, n_rx} = '0;
        seed = 32'd59033;
        do_reset();
        // UART lock: random rate not above one thirty-second of the clock.
        seed = xs(seed);
        bit_ns = 8 * (AUTOBAUD_RATIO + int'(seed[5:0]));
        i_sllf_host.uart_send(SYNC_BYTE, bit_ns);
        fork
            i_sllf_host.uart_send(SYNC_BYTE, bit_ns);
            i_sllf_host.uart_recv(b, ok, bit_ns);
        join
        cmp(b, ACK_BYTE);
        cmp({7'h0, ok}, 8'h01);
        cmp({6'h0, port_o, synced_o}, 8'h03);
        cmp(8'(n_rx), 8'h00);
        n0 = n_rx;
        i_sllf_host.spi_xfer(8'h5a, r);
        cmp(8'(n_rx - n0), 8'h00);
        seed = xs(seed);
        m = seed[7:0];
        i_sllf_host.uart_send(m, bit_ns);
        wait_rx(n0);
        cmp(rx_last, m);
        seed = xs(seed);
        fork
            offer(seed[15:8]);
            i_sllf_host.uart_recv(b, ok, bit_ns);
        join
        cmp(b, seed[15:8]);
        $display("uart test done");
        // SSI lock, then the UART must stay silent.
        do_reset();
        seed = xs(seed);
        n0 = n_rx;
        fork
            offer(seed[7:0]);
            begin
                #40;
                i_sllf_host.spi_xfer(seed[15:8], r);
            end
        join
        cmp(r, seed[7:0]);
        wait_rx(n0);
        cmp(rx_last, seed[15:8]);
        n0 = n_rx;
        i_sllf_host.spi_xfer(8'hff, r);
        cmp(r, 8'h00);
        wait_rx(n0);
        cmp(rx_last, 8'hff);
        i_sllf_host.uart_send(SYNC_BYTE, 512);
        fork
            i_sllf_host.uart_send(SYNC_BYTE, 512);
            i_sllf_host.uart_recv(b, ok, 512);
        join
        cmp({6'h0, port_o, ok}, 8'h04);
        $display("ssi test done");
        end_sim();
    end
endmodule
